/* File: verilog/qfd_pkg.sv */
// qfd_pkg: opcodes, phase codes, lane widths and fixed counts
// for the serial flash command decoder.
// assumes: compiled before the decoder; nothing else is needed.
package qfd_pkg;
	// one-byte instructions
	localparam logic [7:0] OP_SET_WL = 8'h06;
	localparam logic [7:0] OP_CLR_WL = 8'h04;
	localparam logic [7:0] OP_VOL_WE = 8'h50;
	localparam logic [7:0] OP_EN4B = 8'hB7;
	localparam logic [7:0] OP_EX4B = 8'hE9;
	localparam logic [7:0] OP_SUSP = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7A;
	localparam logic [7:0] OP_GLOCK = 8'h7E;
	localparam logic [7:0] OP_GUNLOCK = 8'h98;
	localparam logic [7:0] OP_PWRDN = 8'hB9;
	localparam logic [7:0] OP_RST_EN = 8'h66;
	localparam logic [7:0] OP_RST = 8'h99;
	localparam logic [7:0] OP_CE = 8'hC7;
	localparam logic [7:0] OP_CE2 = 8'h60;
	// register access
	localparam logic [7:0] OP_RD_ST1 = 8'h05;
	localparam logic [7:0] OP_RD_ST2 = 8'h35;
	localparam logic [7:0] OP_RD_ST3 = 8'h15;
	localparam logic [7:0] OP_RD_EXT = 8'hC8;
	localparam logic [7:0] OP_WR_EXT = 8'hC5;
	// single lane address
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_READ4 = 8'h13;
	localparam logic [7:0] OP_FAST = 8'h0B;
	localparam logic [7:0] OP_FAST4 = 8'h0C;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_PP4 = 8'h12;
	localparam logic [7:0] OP_QPP = 8'h32;
	localparam logic [7:0] OP_QPP4 = 8'h34;
	localparam logic [7:0] OP_SE = 8'h20;
	localparam logic [7:0] OP_SE4 = 8'h21;
	localparam logic [7:0] OP_BE32 = 8'h52;
	localparam logic [7:0] OP_BE64 = 8'hD8;
	localparam logic [7:0] OP_BE64_4 = 8'hDC;
	localparam logic [7:0] OP_SEC_ER = 8'h44;
	localparam logic [7:0] OP_SEC_PG = 8'h42;
	localparam logic [7:0] OP_SEC_RD = 8'h48;
	localparam logic [7:0] OP_DOR = 8'h3B;
	localparam logic [7:0] OP_DOR4 = 8'h3C;
	localparam logic [7:0] OP_QOR = 8'h6B;
	localparam logic [7:0] OP_QOR4 = 8'h6C;
	// multi lane address
	localparam logic [7:0] OP_DIO = 8'hBB;
	localparam logic [7:0] OP_DIO4 = 8'hBC;
	localparam logic [7:0] OP_QIO = 8'hEB;
	localparam logic [7:0] OP_QIO4 = 8'hEC;
	localparam logic [7:0] OP_DID = 8'h92;
	localparam logic [7:0] OP_QID = 8'h94;
	// lane widths, bits per clock
	localparam logic [2:0] W1 = 3'h1;
	localparam logic [2:0] W2 = 3'h2;
	localparam logic [2:0] W4 = 3'h4;
	// phase lengths in link clocks
	localparam logic [6:0] OPC_CLKS = 7'h08;
	localparam logic [3:0] DUMMY_BYTE_CLKS = 4'h8;
	localparam logic [3:0] QIO_DUMMY_CLKS = 4'h4;
	// address and mode fields
	localparam logic [7:0] SEC_TOP = 8'h00;
	localparam logic [7:0] SEC_PG1 = 8'h10;
	localparam logic [7:0] SEC_PG2 = 8'h20;
	localparam logic [7:0] SEC_PG3 = 8'h30;
	localparam logic [1:0] CONT_BITS = 2'h2;
	localparam int PAGE_BYTES = 256;
	// status bit positions
	localparam int ST1_BUSY_BIT = 0;
	localparam int ST1_WL_BIT = 1;
	localparam int ST3_A4_BIT = 0;
	// values after reset
	localparam logic [7:0] EXT_RST = 8'h00;
	localparam logic A4_RST = 1'b0;
	typedef enum logic [2:0] {
		ST_OPC = 3'b000,
		ST_ADDR = 3'b001,
		ST_MODE = 3'b010,
		ST_DUMMY = 3'b011,
		ST_DIN = 3'b100,
		ST_DOUT = 3'b101,
		ST_IGNORE = 3'b110
	} qfd_state_t;
	typedef enum logic [1:0] {
		DIR_NONE = 2'b00,
		DIR_IN = 2'b01,
		DIR_OUT = 2'b10
	} qfd_dir_t;
	typedef enum logic [1:0] {
		SRC_STAT = 2'b00,
		SRC_EXT = 2'b01,
		SRC_ID = 2'b10,
		SRC_BUF = 2'b11
	} qfd_src_t;
	typedef struct packed {
		logic [2:0] nb;
		logic [2:0] aw;
		logic mode;
		logic [3:0] dummy;
		qfd_dir_t dir;
		logic [2:0] dw;
		qfd_src_t src;
		logic gated;
		logic known;
	} qfd_dec_t;
endpackage

/* File: verilog/qfd_cmd_decode.sv */
// qfd_cmd_decode: instruction decoder and transfer framing of a
// serial flash slave with one, two and four data lanes.
// assumes: host drives spi_clk and cs_n; cs_n stays high at least
// four ref_clk periods between frames; busy comes from ref_clk logic.
`timescale 1ns/1ns
module qfd_cmd_decode #(
	parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
	parameter logic [7:0] PART_CODE = 8'hC3 // arbitrary value
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic spi_clk,
	input wire logic cs_n,
	input wire logic lane_0_in,
	input wire logic lane_1_in,
	input wire logic lane_2_in,
	input wire logic lane_3_in,
	output logic lane_0_out,
	output logic lane_1_out,
	output logic lane_2_out,
	output logic lane_3_out,
	output logic lane_0_oe,
	output logic lane_1_oe,
	output logic lane_2_oe,
	output logic lane_3_oe,
	input wire logic busy,
	input wire logic [7:0] page_rd_idx,
	output logic [7:0] page_rd_data,
	output logic op_valid,
	output logic [7:0] op_code,
	output logic [31:0] op_addr,
	output logic [15:0] op_bytes,
	output logic suspend_req,
	output logic resume_req,
	output logic addr4_mode,
	output logic write_latch_armed,
	output logic [7:0] upper_address_byte
);
	import qfd_pkg::*;

	// instruction table: phases and lanes per opcode
	function automatic qfd_dec_t decode(input logic [7:0] o,
		input logic a4);
		qfd_dec_t d;
		d = '0;
		d.known = 1'b1;
		d.nb = a4 ? 3'h4 : 3'h3;
		case (o)
			OP_SET_WL, OP_CLR_WL, OP_EN4B, OP_EX4B, OP_SUSP, OP_RESUME,
			OP_GLOCK, OP_GUNLOCK, OP_PWRDN, OP_RST_EN, OP_RST,
			OP_VOL_WE: d.known = 1'b1;
			OP_CE, OP_CE2: d.gated = 1'b1;
			OP_RD_ST1, OP_RD_ST2, OP_RD_ST3, OP_RD_EXT: begin
				d.dir = DIR_OUT;
				d.dw = W1;
				d.src = (o == OP_RD_EXT) ? SRC_EXT : SRC_STAT;
			end
			OP_WR_EXT: begin
				d.dir = DIR_IN;
				d.dw = W1;
				d.gated = 1'b1;
			end
			OP_READ, OP_READ4, OP_FAST, OP_FAST4, OP_SEC_RD, OP_DOR,
			OP_DOR4, OP_QOR, OP_QOR4: begin
				d.aw = W1;
				d.dir = DIR_OUT;
				d.src = SRC_BUF;
				d.dw = (o == OP_DOR || o == OP_DOR4) ? W2 :
					(o == OP_QOR || o == OP_QOR4) ? W4 : W1;
				if (o != OP_READ && o != OP_READ4)
					d.dummy = DUMMY_BYTE_CLKS;
			end
			OP_PP, OP_PP4, OP_SEC_PG, OP_QPP, OP_QPP4: begin
				d.aw = W1;
				d.dir = DIR_IN;
				d.gated = 1'b1;
				d.dw = (o == OP_QPP || o == OP_QPP4) ? W4 : W1;
			end
			OP_SE, OP_SE4, OP_BE32, OP_BE64, OP_BE64_4,
			OP_SEC_ER: begin
				d.aw = W1;
				d.gated = 1'b1;
			end
			OP_DIO, OP_DIO4, OP_DID: begin
				d.aw = W2;
				d.mode = 1'b1;
				d.dir = DIR_OUT;
				d.dw = W2;
				d.src = (o == OP_DID) ? SRC_ID : SRC_BUF;
			end
			OP_QIO, OP_QIO4, OP_QID: begin
				d.aw = W4;
				d.mode = 1'b1;
				d.dummy = QIO_DUMMY_CLKS;
				d.dir = DIR_OUT;
				d.dw = W4;
				d.src = (o == OP_QID) ? SRC_ID : SRC_BUF;
			end
			default: d.known = 1'b0;
		endcase
		// explicit 4-byte forms ignore the address mode
		if (o == OP_READ4 || o == OP_FAST4 || o == OP_PP4 ||
			o == OP_QPP4 || o == OP_SE4 || o == OP_BE64_4 ||
			o == OP_DOR4 || o == OP_QOR4 || o == OP_DIO4 || o == OP_QIO4)
			d.nb = 3'h4;
		return d;
	endfunction

	// clocks per byte for a lane width: 8, 4 or 2
	function automatic logic [6:0] cpb(input logic [2:0] w);
		return {3'h0, w[0], w[1], w[2], 1'b0};
	endfunction

	// msb-first shift of w new bits
	function automatic logic [31:0] shin(input logic [31:0] s,
		input logic [2:0] w, input logic [3:0] l);
		case (w)
			W4: return {s[27:0], l};
			W2: return {s[29:0], l[1:0]};
			default: return {s[30:0], l[0]};
		endcase
	endfunction

	logic frame_rst; // framing dies with every deselect
	logic [3:0] lanes; // sampled lane levels
	qfd_state_t st, st_eff, next_st; // transfer phase
	logic [6:0] cnt, next_cnt; // clocks into phase or byte
	logic [31:0] sh, next_sh; // input shifter
	logic [7:0] out_sh, next_out; // output shifter
	logic [7:0] ptr, next_ptr; // page byte pointer
	logic idsel, next_idsel; // maker or part code next
	logic [7:0] op, next_op; // last opcode, kept over frames
	logic [31:0] addr, next_addr; // last address
	logic cmd_ok, next_ok; // frame reached its valid point
	logic wl, next_wl; // write latch
	logic a4, next_a4; // 4-byte address mode
	logic [7:0] ext, next_ext; // upper address byte
	logic cont, next_cont; // skip opcode on next frame
	logic [15:0] prog_bytes, next_bytes; // data bytes taken
	logic buf_we; // page write strobe
	logic [7:0] buf_wa, buf_wd;
	logic [7:0] page_mem [PAGE_BYTES]; // program data window
	qfd_dec_t dc, dn; // decode of held and next opcode
	logic [6:0] seg_len; // length of current phase
	logic last; // final clock of phase or byte
	qfd_state_t data_st; // phase after address extras
	logic load; // fetch a new output byte
	logic [7:0] stat; // status byte for the opcode in flight
	logic busy_meta, busy_s; // busy synchroniser
	logic [3:0] next_lv, next_oe; // lane drive at falling edge

	assign frame_rst = sys_rst | cs_n;
	assign lanes = {lane_3_in, lane_2_in, lane_1_in, lane_0_in};
	assign dc = decode(op, a4);
	// continuous readout starts the frame at the address
	assign st_eff = (st == ST_OPC && cont) ? ST_ADDR : st;

	// busy level into the link domain
	always_ff @(posedge spi_clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_meta <= 1'b0;
			busy_s <= 1'b0;
		end else begin
			busy_meta <= busy;
			busy_s <= busy_meta;
		end
	end

	// status byte contents; keyed on the opcode in flight, because the
	// first byte loads on the same edge that completes the opcode
	always_comb begin
		stat = 8'h00;
		if (next_op == OP_RD_ST1) begin
			stat[ST1_BUSY_BIT] = busy_s;
			stat[ST1_WL_BIT] = wl;
		end else if (next_op == OP_RD_ST3) begin
			stat[ST3_A4_BIT] = a4;
		end
	end

	// phase sequencing, shifting and command effects
	always_comb begin
		next_st = st;
		next_sh = sh;
		next_out = out_sh;
		next_ptr = ptr;
		next_idsel = idsel;
		next_op = op;
		next_addr = addr;
		next_ok = cmd_ok;
		next_wl = wl;
		next_a4 = a4;
		next_ext = ext;
		next_cont = cont;
		next_bytes = prog_bytes;
		buf_we = 1'b0;
		buf_wa = ptr;
		buf_wd = sh[7:0];
		dn = dc;
		load = 1'b0;
		case (st_eff)
			ST_OPC: seg_len = OPC_CLKS;
			ST_ADDR: seg_len = 7'(dc.nb * cpb(dc.aw));
			ST_MODE: seg_len = cpb(dc.aw);
			ST_DUMMY: seg_len = {3'h0, dc.dummy};
			ST_DIN, ST_DOUT: seg_len = cpb(dc.dw);
			default: seg_len = 7'h00;
		endcase
		last = (cnt == seg_len - 7'h01);
		data_st = (dc.dir == DIR_IN) ? ST_DIN :
			(dc.dir == DIR_OUT) ? ST_DOUT : ST_IGNORE;
		// a new frame forgets the previous verdict
		if (st == ST_OPC && cnt == 7'h00)
			next_ok = 1'b0;
		case (st_eff)
			ST_OPC: begin
				next_sh = shin(sh, W1, lanes);
				if (last) begin
					next_op = next_sh[7:0];
					dn = decode(next_op, a4);
					next_bytes = 16'h0000;
					if (!dn.known || (dn.gated && !wl))
						next_st = ST_IGNORE;
					else if (dn.aw != 3'h0)
						next_st = ST_ADDR;
					else if (dn.dir == DIR_OUT)
						next_st = ST_DOUT;
					else if (dn.dir == DIR_IN)
						next_st = ST_DIN;
					else begin
						next_st = ST_IGNORE;
						next_ok = 1'b1;
						case (next_op)
							OP_SET_WL: next_wl = 1'b1;
							OP_CLR_WL, OP_CE, OP_CE2: next_wl = 1'b0;
							OP_EN4B: next_a4 = 1'b1;
							OP_EX4B: next_a4 = 1'b0;
							default: next_ok = 1'b1;
						endcase
					end
				end
			end
			ST_ADDR: begin
				next_sh = shin(sh, dc.aw, lanes);
				if (last) begin
					next_addr = (dc.nb == 3'h4) ? next_sh :
						{ext, next_sh[23:0]};
					next_ptr = next_addr[7:0];
					if ((op == OP_SEC_ER || op == OP_SEC_PG ||
						op == OP_SEC_RD) &&
						(next_addr[23:16] != SEC_TOP ||
						(next_addr[15:8] != SEC_PG1 &&
						next_addr[15:8] != SEC_PG2 &&
						next_addr[15:8] != SEC_PG3)))
						next_st = ST_IGNORE;
					else if (dc.mode)
						next_st = ST_MODE;
					else if (dc.dummy != 4'h0)
						next_st = ST_DUMMY;
					else if (dc.dir == DIR_NONE) begin
						next_st = ST_IGNORE;
						next_ok = 1'b1;
						next_wl = 1'b0;
					end else
						next_st = data_st;
				end
			end
			ST_MODE: begin
				next_sh = shin(sh, dc.aw, lanes);
				if (last) begin
					// mode bits 5:4 equal to CONT_BITS keep continuous reads on; any other value ends them
					if (dc.src == SRC_BUF)
						next_cont = (next_sh[5:4] == CONT_BITS);
					next_st = (dc.dummy != 4'h0) ? ST_DUMMY : data_st;
				end
			end
			ST_DUMMY: begin
				if (last)
					next_st = data_st;
			end
			ST_DIN: begin
				next_sh = shin(sh, dc.dw, lanes);
				if (last && op == OP_WR_EXT) begin
					next_ext = next_sh[7:0];
					next_ok = 1'b1;
					next_wl = 1'b0;
					next_st = ST_IGNORE;
				end else if (last) begin
					buf_we = 1'b1;
					buf_wa = ptr;
					buf_wd = next_sh[7:0];
					next_ptr = ptr + 8'h01;
					next_bytes = prog_bytes + 16'h0001;
					next_ok = 1'b1;
					next_wl = 1'b0;
				end
			end
			default: next_st = st;
		endcase
		dn = decode(next_op, next_a4);
		load = (next_st == ST_DOUT) && (st_eff != ST_DOUT || last);
		if (load) begin
			// reaching the data phase makes a read frame count
			next_ok = 1'b1;
			case (dn.src)
				SRC_STAT: next_out = stat;
				SRC_EXT: next_out = ext;
				SRC_ID: begin
					next_out = idsel ? PART_CODE : MAKER_CODE;
					next_idsel = ~idsel;
				end
				default: begin
					next_out = page_mem[next_ptr];
					next_ptr = next_ptr + 8'h01;
				end
			endcase
		end else if (st_eff == ST_DOUT)
			next_out = out_sh << dn.dw;
		next_cnt = (next_st != st_eff || last) ? 7'h00 : cnt + 7'h01;
	end

	// framing state, cleared by deselect
	always_ff @(posedge spi_clk or posedge frame_rst) begin
		if (frame_rst) begin
			st <= ST_OPC;
			cnt <= 7'h00;
			sh <= 32'h0000_0000;
			out_sh <= 8'h00;
			ptr <= 8'h00;
			idsel <= 1'b0;
		end else begin
			st <= next_st;
			cnt <= next_cnt;
			sh <= next_sh;
			out_sh <= next_out;
			ptr <= next_ptr;
			idsel <= next_idsel;
		end
	end

	// state that outlives the frame; read by ref_clk after deselect
	always_ff @(posedge spi_clk or posedge sys_rst) begin
		if (sys_rst) begin
			op <= 8'h00;
			addr <= 32'h0000_0000;
			cmd_ok <= 1'b0;
			wl <= 1'b0;
			a4 <= A4_RST;
			ext <= EXT_RST;
			cont <= 1'b0;
			prog_bytes <= 16'h0000;
		end else begin
			op <= next_op;
			addr <= next_addr;
			cmd_ok <= next_ok;
			wl <= next_wl;
			a4 <= next_a4;
			ext <= next_ext;
			cont <= next_cont;
			prog_bytes <= next_bytes;
		end
	end

	// page data, no reset: contents are data, not control
	always_ff @(posedge spi_clk) begin
		if (buf_we)
			page_mem[buf_wa] <= buf_wd;
	end

	// lane drive; lanes float during address and dummy clocks
	always_comb begin
		next_lv = 4'h0;
		next_oe = 4'h0;
		if (st == ST_DOUT) begin
			case (dc.dw)
				W4: begin
					next_lv = out_sh[7:4];
					next_oe = 4'hF;
				end
				W2: begin
					next_lv = {2'h0, out_sh[7:6]};
					next_oe = 4'h3;
				end
				default: begin
					next_lv = {2'h0, out_sh[7], 1'b0};
					next_oe = 4'h2;
				end
			endcase
		end
	end

	// output lanes change on the falling link clock
	always_ff @(negedge spi_clk or posedge frame_rst) begin
		if (frame_rst) begin
			{lane_3_out, lane_2_out, lane_1_out, lane_0_out} <= 4'h0;
			{lane_3_oe, lane_2_oe, lane_1_oe, lane_0_oe} <= 4'h0;
		end else begin
			{lane_3_out, lane_2_out, lane_1_out, lane_0_out} <= next_lv;
			{lane_3_oe, lane_2_oe, lane_1_oe, lane_0_oe} <= next_oe;
		end
	end

	// ref_clk side: deselect, synchronised, qualifies the words
	logic cs_meta, cs_sync, cs_prev, cs_rise;
	logic next_valid, next_susp, next_res;
	assign cs_rise = cs_sync & ~cs_prev;

	always_comb begin
		next_valid = cs_rise & cmd_ok;
		next_susp = cs_rise & cmd_ok & (op == OP_SUSP);
		next_res = cs_rise & cmd_ok & (op == OP_RESUME);
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cs_meta <= 1'b1;
			cs_sync <= 1'b1;
			cs_prev <= 1'b1;
			op_valid <= 1'b0;
			op_code <= 8'h00;
			op_addr <= 32'h0000_0000;
			op_bytes <= 16'h0000;
			suspend_req <= 1'b0;
			resume_req <= 1'b0;
			addr4_mode <= A4_RST;
			write_latch_armed <= 1'b0;
			upper_address_byte <= EXT_RST;
			page_rd_data <= 8'h00;
		end else begin
			cs_meta <= cs_n;
			cs_sync <= cs_meta;
			cs_prev <= cs_sync;
			op_valid <= next_valid;
			suspend_req <= next_susp;
			resume_req <= next_res;
			page_rd_data <= page_mem[page_rd_idx];
			if (cs_rise) begin
				op_code <= op;
				op_addr <= addr;
				op_bytes <= prog_bytes;
				addr4_mode <= a4;
				write_latch_armed <= wl;
				upper_address_byte <= ext;
			end
		end
	end
endmodule

/* File: tb/qfd_cmd_decode_props.sv */
// qfd_cmd_decode_chk: timing checks on the decoder's ports.
// assumes: bound to every decoder instance, qfd_pkg compiled first.
`timescale 1ns/1ns
module qfd_cmd_decode_chk (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic spi_clk,
	input wire logic cs_n,
	input wire logic lane_0_in,
	input wire logic lane_0_oe,
	input wire logic lane_1_oe,
	input wire logic lane_2_oe,
	input wire logic lane_3_oe,
	input wire logic op_valid,
	input wire logic [7:0] op_code,
	input wire logic suspend_req,
	input wire logic resume_req,
	input wire logic addr4_mode,
	input wire logic write_latch_armed,
	input wire logic [7:0] upper_address_byte
);
	import qfd_pkg::*;
	logic [7:0] fop; // first byte of the frame on lane 0
	logic [3:0] nb; // opcode bits seen so far
	// select high restarts the count; the byte itself is kept
	always_ff @(posedge spi_clk or posedge cs_n) begin
		if (cs_n) begin
			nb <= 4'h0;
		end else if (nb < 4'h8) begin
			fop <= {fop[6:0], lane_0_in};
			nb <= nb + 4'h1;
		end
	end
	a4_on_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		$rose(addr4_mode) |-> fop == OP_EN4B) else $error("mode on stray");
	a4_off_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		$fell(addr4_mode) |-> fop == OP_EX4B) else $error("mode off stray");
	latch_set_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		$rose(write_latch_armed) |-> fop == OP_SET_WL) else $error("latch");
	ext_write_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		$changed(upper_address_byte) |-> fop == OP_WR_EXT) else $error("ext");
	susp_pulse_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst) suspend_req |->
		op_valid && op_code == OP_SUSP && !resume_req) else $error("susp");
	resume_pulse_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst) resume_req |->
		op_valid && op_code == OP_RESUME) else $error("resume");
	pulse_once_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		op_valid |=> !op_valid [*3]) else $error("pulse too long");
	after_desel_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		op_valid |-> cs_n && $past(cs_n, 2)) else $error("pulse early");
	desel_quiet_a: assert property (
		@(posedge ref_clk) disable iff (sys_rst) cs_n |->
		!(lane_0_oe || lane_1_oe || lane_2_oe || lane_3_oe))
		else $error("drive while deselected");
	opc_quiet_a: assert property (
		@(posedge spi_clk) disable iff (sys_rst || cs_n)
		nb < 4'h8 |-> !lane_1_oe) else $error("drive during opcode");
	lane_group_a: assert property (
		@(posedge spi_clk) disable iff (sys_rst)
		(lane_2_oe == lane_3_oe) && (!lane_0_oe || lane_1_oe)
		&& (!lane_2_oe || lane_0_oe)) else $error("lane enables split");
	// main scenarios reached
	cover property (@(posedge ref_clk) op_valid && op_code == OP_QIO4);
	cover property (@(posedge ref_clk) suspend_req);
	cover property (@(posedge ref_clk) $rose(addr4_mode));
endmodule

bind qfd_cmd_decode qfd_cmd_decode_chk chk (.ref_clk, .sys_rst,
	.spi_clk, .cs_n, .lane_0_in, .lane_0_oe, .lane_1_oe, .lane_2_oe,
	.lane_3_oe, .op_valid, .op_code, .suspend_req, .resume_req,
	.addr4_mode, .write_latch_armed, .upper_address_byte);

/* File: tb/qfd_host.sv */
// qfd_host: host controller model; link clock, select and lanes.
// assumes: link clock idles low, 160 ns period, called between frames.
`timescale 1ns/1ns
module qfd_host (
	output logic spi_clk,
	output logic cs_n,
	output logic [3:0] lin,
	input wire logic [3:0] lout,
	input wire logic [3:0] loe,
	output logic [7:0] rx,
	output logic stb
);
	logic [3:0] hv; // host lane drive
	logic [7:0] sh; // outgoing byte
	// device wins where its enable is high
	assign lin = (loe & lout) | (~loe & hv);
	initial begin
		spi_clk = 1'b0;
		cs_n = 1'b1;
		hv = 4'hF;
		rx = 8'h00;
		stb = 1'b0;
	end
	// 3 ns off the system clock so no edge ties with it
	task sel;
		#43 cs_n = 1'b0;
		#80;
	endtask
	// long gap: the deselect must be seen on the system side
	task done;
		#80 cs_n = 1'b1;
		hv = ~hv;
		#405;
	endtask
	// one byte on w lanes, msb first; rd shifts device bits in
	task tx(input logic [7:0] b, input int w, input bit rd);
		int k;
		sh = b;
		for (k = 0; k < 8 / w; k++) begin
			if (w == 1)
				hv[0] = sh[7];
			else if (w == 2)
				hv[1:0] = sh[7:6];
			else
				hv = sh[7:4];
			#80 spi_clk = 1'b1;
			if (rd) begin
				if (w == 1)
					rx = {rx[6:0], lin[1]};
				else if (w == 2)
					rx = {rx[5:0], lin[1:0]};
				else
					rx = {rx[3:0], lin};
				hv = ~hv;
				// strobe on the last rise; taking no time keeps the
				// 3 ns offset from the system clock for later frames
				stb = (k == 8 / w - 1);
			end
			sh = sh << w;
			#80 spi_clk = 1'b0;
			stb = 1'b0;
		end
	endtask
endmodule

/* File: tb/qspi_flash_cmd_decode_4byte_bench.sv */
// qspi_flash_cmd_decode_4byte_bench: self-checking decoder bench.
// assumes: package, decoder, host model and checker compiled first.
`timescale 1ns/1ns
module qspi_flash_cmd_decode_4byte_bench;
	import qfd_pkg::*;
	localparam logic [7:0] MK = 8'h3C; // arbitrary value
	localparam logic [7:0] PT = 8'hA5; // arbitrary value
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic busy = 1'b0;
	logic [7:0] page_rd_idx = 8'h00;
	wire spi_clk, cs_n, rx_stb, op_valid, suspend_req, resume_req;
	wire addr4_mode, write_latch_armed;
	wire [3:0] lin, lout, loe;
	wire [7:0] rx, page_rd_data, op_code, upper_address_byte;
	wire [31:0] op_addr;
	wire [15:0] op_bytes;
	logic [7:0] exp_rd[$]; // read bytes still due
	logic [7:0] exp_op[$]; // accepted frames still due
	logic [7:0] eo; // oldest accepted frame
	logic [7:0] pg[256]; // expected page window
	int mismatches = 0;
	int total_checks = 0;
	int seed = 19145;
	int cyc = 0;
	always #4 ref_clk = ~ref_clk;
	qfd_host h (.spi_clk(spi_clk), .cs_n(cs_n), .lin(lin), .lout(lout),
		.loe(loe), .rx(rx), .stb(rx_stb));
	qfd_cmd_decode #(.MAKER_CODE(MK), .PART_CODE(PT)) uut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .spi_clk(spi_clk),
		.cs_n(cs_n), .lane_0_in(lin[0]), .lane_1_in(lin[1]),
		.lane_2_in(lin[2]), .lane_3_in(lin[3]), .lane_0_out(lout[0]),
		.lane_1_out(lout[1]), .lane_2_out(lout[2]), .lane_3_out(lout[3]),
		.lane_0_oe(loe[0]), .lane_1_oe(loe[1]), .lane_2_oe(loe[2]),
		.lane_3_oe(loe[3]), .busy(busy), .page_rd_idx(page_rd_idx),
		.page_rd_data(page_rd_data), .op_valid(op_valid),
		.op_code(op_code), .op_addr(op_addr), .op_bytes(op_bytes),
		.suspend_req(suspend_req), .resume_req(resume_req),
		.addr4_mode(addr4_mode), .write_latch_armed(write_latch_armed),
		.upper_address_byte(upper_address_byte));
	task report_and_stop;
		if (mismatches == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// one-byte frame; ok says whether a pulse is due
	task op1(input logic [7:0] b, input bit ok);
		h.sel();
		h.tx(b, 1, 1'b0);
		// noted before deselect: the pulse comes during done
		if (ok)
			exp_op.push_back(b);
		h.done();
	endtask
	// register read, n repeats of the same byte
	task st(input logic [7:0] op, input logic [7:0] e, input int n);
		h.sel();
		h.tx(op, 1, 1'b0);
		repeat (n) begin
			exp_rd.push_back(e);
			h.tx(8'h00, 1, 1'b1);
		end
		exp_op.push_back(op);
		h.done();
	endtask
	// read frame: address lanes, mode, dummy clocks, data lanes
	task rdx(input logic [7:0] op, input int aw, input bit md,
		input int dm, input int dw, input logic [31:0] a, input bit id);
		int i;
		h.sel();
		h.tx(op, 1, 1'b0);
		for (i = 3; i >= 0; i--)
			h.tx(a[8*i+:8], aw, 1'b0);
		if (md)
			h.tx(8'hF0, aw, 1'b0);
		for (i = 0; i < dm * aw / 8; i++)
			h.tx(8'($random(seed)), aw, 1'b0);
		for (i = 0; i < 4; i++) begin
			exp_rd.push_back(id ? (i[0] ? PT : MK) : pg[8'(a[7:0] + i)]);
			h.tx(8'h00, dw, 1'b1);
		end
		exp_op.push_back(op);
		h.done();
	endtask
	// page window read, data one cycle after the index
	task pgchk(input logic [7:0] idx);
		@(negedge ref_clk) page_rd_idx = idx;
		repeat (2) @(negedge ref_clk);
		chk(page_rd_data, pg[idx]);
	endtask
	always @(posedge rx_stb) chk(rx, exp_rd.pop_front());
	always @(negedge ref_clk) begin
		if (op_valid === 1'b1) begin
			eo = exp_op.pop_front();
			chk(op_code, eo);
			chk(suspend_req, eo == OP_SUSP);
			chk(resume_req, eo == OP_RESUME);
		end
		cyc++;
		if (cyc == 80000) begin
			mismatches++;
			report_and_stop();
		end
	end
	initial begin
		int i;
		logic [7:0] b;
		repeat (16) @(negedge ref_clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge ref_clk);
		chk(addr4_mode, A4_RST);
		chk(upper_address_byte, EXT_RST);
		chk(write_latch_armed, 1'b0);
		op1(OP_EN4B, 1'b1);
		chk(addr4_mode, 1'b1);
		op1(8'hFF, 1'b0);
		// program with the latch clear is dropped
		h.sel();
		repeat (6) h.tx(OP_QPP, 1, 1'b0);
		h.done();
		op1(OP_SET_WL, 1'b1);
		chk(write_latch_armed, 1'b1);
		b = 8'($random(seed));
		h.sel();
		h.tx(OP_WR_EXT, 1, 1'b0);
		h.tx(b, 1, 1'b0);
		exp_op.push_back(OP_WR_EXT);
		h.done();
		chk(upper_address_byte, b);
		st(OP_RD_EXT, b, 1);
		@(negedge ref_clk) busy = 1'($random(seed));
		repeat (4) @(negedge ref_clk);
		st(OP_RD_ST1, {7'h00, busy}, 3);
		st(OP_RD_ST3, 8'h01, 3);
		op1(OP_SET_WL, 1'b1);
		// 258 quad bytes from FEh: the last two land on FEh, FFh again
		h.sel();
		h.tx(OP_QPP, 1, 1'b0);
		for (i = 0; i < 4; i++)
			h.tx(8'(32'h000012FE >> (24 - 8 * i)), 1, 1'b0);
		for (i = 0; i < 258; i++) begin
			b = 8'($random(seed));
			pg[8'(8'hFE + i)] = b;
			h.tx(b, 4, 1'b0);
		end
		exp_op.push_back(OP_QPP);
		h.done();
		chk(op_bytes, 16'h0102);
		chk(op_addr, 32'h000012FE);
		chk(write_latch_armed, 1'b0);
		for (i = 0; i < 4; i++)
			pgchk(8'(8'hFE + i));
		rdx(OP_FAST4, 1, 1'b0, 8, 1, 32'h000012FC, 1'b0);
		rdx(OP_READ4, 1, 1'b0, 0, 1, 32'h000012FD, 1'b0);
		rdx(OP_DOR4, 1, 1'b0, 8, 2, 32'h000012FC, 1'b0);
		rdx(OP_QOR4, 1, 1'b0, 8, 4, 32'h000012FC, 1'b0);
		rdx(OP_DIO4, 2, 1'b1, 0, 2, 32'h000012FC, 1'b0);
		rdx(OP_QIO4, 4, 1'b1, 4, 4, 32'h000012FC, 1'b0);
		rdx(OP_QID, 4, 1'b1, 4, 4, 32'h00001200, 1'b1);
		rdx(OP_DID, 2, 1'b1, 0, 2, 32'h00001200, 1'b1);
		rdx(OP_SEC_RD, 1, 1'b0, 8, 1, 32'h000030FC, 1'b0);
		// security read outside the three pages is dropped
		h.sel();
		h.tx(OP_SEC_RD, 1, 1'b0);
		for (i = 0; i < 4; i++)
			h.tx(i == 2 ? 8'h40 : 8'h00, 1, 1'b0);
		h.done();
		op1(OP_SUSP, 1'b1);
		op1(OP_RESUME, 1'b1);
		op1(OP_EX4B, 1'b1);
		chk(addr4_mode, 1'b0);
		chk(exp_op.size(), 0);
		chk(exp_rd.size(), 0);
		report_and_stop();
	end
endmodule
